// File: include/mgf_pkg.sv
// Package for the monitor, user I/O and fault register bank.
// Assumes a byte-wide register port fed by the device's serial slave.
package mgf_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_ADC_SETUP = 8'hc0;
   localparam logic [7:0] ADDR_BUS_CURRENT = 8'hc3;
   localparam logic [7:0] ADDR_THERM_VOLT = 8'hc4;
   localparam logic [7:0] ADDR_UIO_DIR = 8'hc8;
   localparam logic [7:0] ADDR_UIO_DRIVE = 8'hc9;
   localparam logic [7:0] ADDR_UIO_SAMPLED = 8'hca;
   localparam logic [7:0] ADDR_ROLE_SETTLED = 8'hcb;
   localparam logic [7:0] ADDR_OV_SETUP = 8'hcc;
   localparam logic [7:0] ADDR_OV_FLAGS = 8'hcd;
   // Reset values
   localparam logic [7:0] RST_ADC_SETUP = 8'h81;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // adc_setup fields
   localparam int ADC_KEEP_BIT = 7;
   localparam int BIAS_LSB = 5;
   localparam int DEB_LSB = 3;
   localparam int SCAN_LSB = 0;
   localparam logic [2:0] SCAN_CODE_MAX = 3'h5;
   localparam int SCAN_BASE_SHIFT = 2;
   // role_settled_control field
   localparam int ROLE_BIT = 5;
   // overvoltage_setup fields
   localparam int ALARM_EN_BIT = 7;
   localparam int DL_LEVEL_BIT = 6;
   localparam int DL_CHECK_BIT = 5;
   localparam int BUS_CHECK_BIT = 4;
   localparam int BUS_THR_LSB = 0;
   // overvoltage_flags fields
   localparam int FLAG_DL = 2;
   localparam int FLAG_BUS = 1;
   localparam int FLAG_CC = 0;
   // Number of user I/O pins
   localparam int UIO_N = 3;
   // Timing
   localparam int CLK_HZ = 100000000;
   localparam int MS_TIME_US = 1000;
   localparam int MS_CYCLES = CLK_HZ / 1000000 * MS_TIME_US;
endpackage : mgf_pkg

// File: rtl/mgf_regs.sv
// Register bank: ADC setup/results, three user I/O pins, role-settled flag,
// overvoltage enables, thresholds, sticky flags and fault alarm on pin 2.
// Assumes a same-clock byte register port; comparator and pin inputs are async.
//
// Functional notes
// - Bits 6:5 pick thermistor bias: 1.25uA, 5uA, 20uA, 100uA.
// - Bits 4:3 give zero to three extra ADC debounce repetitions.
// - Bits 2:0 pick scan interval 4ms to 128ms; reset code 001.
// - Read-only bus-current code, reset zero.
// - Read-only thermistor voltage code, reset zero, 9.41mV per step.
// - Direction bits 0..2: 0 input, 1 output; reset all inputs.
// - Output pins drive their data bit, pin 2 only while alarm bit 7 is clear; host sets direction first.
// - Input bits return sampled pin levels; host makes pin input first.
// - Host sets role-settled when connected, clears when detached.
// - Alarm enable bit 7 drives pin 2 high on any overvoltage.
// - Bit 6 selects data-line threshold 4V or 4.5V.
// - Data-line check only while bit 5 is set.
// - Bus check only while bit 4 is set.
// - Bits 3:0 select bus threshold, 6V up to 24V.
// - Flags: data-line bit 2, bus bit 1, config channel bit 0.
// - ADC setup at 0xc0, reset 0x81.
// - Fixed 6.5V config channel level sets its flag.
`timescale 1ns/100ps
module mgf_regs #(
   parameter int MS_CYCLES = mgf_pkg::MS_CYCLES
) (
   input wire logic clock, // System clock
   input wire logic nrst, // Async reset, active low
   input wire logic [7:0] reg_addr, // Register offset
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata, // Read data, next cycle
   output logic adc_start, // Conversion start pulse
   input wire logic adc_done, // Conversion done pulse
   input wire logic [7:0] adc_bus_current_code, // Converter bus current
   input wire logic [7:0] adc_thermistor_code, // Converter thermistor voltage
   output logic [1:0] thermistor_bias_select, // Thermistor pin bias code
   input wire logic [2:0] uio_in, // User I/O pin levels
   output logic [2:0] uio_out, // User I/O drive levels
   output logic [2:0] uio_oe, // User I/O output enables
   output logic role_settled, // Leaves power saving when high
   input wire logic dataline_ov_cmp, // Data-line comparator
   input wire logic bus_ov_cmp, // Bus comparator
   input wire logic cc_ov_cmp, // Config channel comparator
   output logic dataline_overvolt_level, // Data-line threshold select
   output logic dataline_overvolt_check, // Data-line comparator enable
   output logic bus_overvolt_check, // Bus comparator enable
   output logic [3:0] bus_overvolt_threshold // Bus threshold select
);
   localparam int NS = 3 + mgf_pkg::UIO_N;

   logic [7:0] adc_setup_r;
   logic [7:0] bus_current_r;
   logic [7:0] therm_r;
   logic [2:0] dir_r;
   logic [2:0] drive_r;
   logic role_r;
   logic [7:0] ov_setup_r;
   logic [2:0] flags_r;
   logic [2:0] flags_nxt;
   logic [NS-1:0] s1_r;
   logic [NS-1:0] s2_r;
   logic [NS-1:0] s3_r;
   logic [NS-1:0] stable_r;
   logic [31:0] scan_cnt_r;
   logic [1:0] rep_r;
   logic [7:0] rdata_nxt;

   // Scan interval in cycles for a code
   function automatic logic [31:0] scan_cycles(input logic [2:0] code);
      logic [2:0] c;
      c = (code > mgf_pkg::SCAN_CODE_MAX) ? mgf_pkg::SCAN_CODE_MAX : code;
      scan_cycles = 32'(MS_CYCLES) << (mgf_pkg::SCAN_BASE_SHIFT + int'(c));
   endfunction : scan_cycles

   // Decoding
   wire wr_adc = reg_wr && (reg_addr == mgf_pkg::ADDR_ADC_SETUP);
   wire wr_dir = reg_wr && (reg_addr == mgf_pkg::ADDR_UIO_DIR);
   wire wr_drive = reg_wr && (reg_addr == mgf_pkg::ADDR_UIO_DRIVE);
   wire wr_role = reg_wr && (reg_addr == mgf_pkg::ADDR_ROLE_SETTLED);
   wire wr_ov = reg_wr && (reg_addr == mgf_pkg::ADDR_OV_SETUP);
   wire rd_flags = reg_rd && (reg_addr == mgf_pkg::ADDR_OV_FLAGS);
   wire [1:0] deb_code = adc_setup_r[mgf_pkg::DEB_LSB +: 2];
   wire [2:0] scan_code = adc_setup_r[mgf_pkg::SCAN_LSB +: 3];
   wire scan_hit = (scan_cnt_r >= scan_cycles(scan_code) - 32'h1);
   wire latch_result = adc_done && (rep_r >= deb_code);
   wire alarm_en = ov_setup_r[mgf_pkg::ALARM_EN_BIT];
   wire dl_ov = stable_r[0];
   wire bus_ov = stable_r[1];
   wire cc_ov = stable_r[2];
   wire [2:0] uio_sampled = stable_r[3 +: 3];
   wire alarm_level = |flags_r;

   // Sticky flags; set beats read-clear
   assign flags_nxt[mgf_pkg::FLAG_DL] = (dl_ov && ov_setup_r[mgf_pkg::DL_CHECK_BIT]) ||
      (flags_r[mgf_pkg::FLAG_DL] && !rd_flags);
   assign flags_nxt[mgf_pkg::FLAG_BUS] = (bus_ov && ov_setup_r[mgf_pkg::BUS_CHECK_BIT]) ||
      (flags_r[mgf_pkg::FLAG_BUS] && !rd_flags);
   assign flags_nxt[mgf_pkg::FLAG_CC] = cc_ov || (flags_r[mgf_pkg::FLAG_CC] && !rd_flags);

   // Read mux; reserved bits zero
   always_comb begin
      case (reg_addr)
         mgf_pkg::ADDR_ADC_SETUP: rdata_nxt = adc_setup_r;
         mgf_pkg::ADDR_BUS_CURRENT: rdata_nxt = bus_current_r;
         mgf_pkg::ADDR_THERM_VOLT: rdata_nxt = therm_r;
         mgf_pkg::ADDR_UIO_DIR: rdata_nxt = {5'h00, dir_r};
         mgf_pkg::ADDR_UIO_DRIVE: rdata_nxt = {5'h00, drive_r};
         mgf_pkg::ADDR_UIO_SAMPLED: rdata_nxt = {5'h00, uio_sampled};
         mgf_pkg::ADDR_ROLE_SETTLED: rdata_nxt = 8'(role_r) << mgf_pkg::ROLE_BIT;
         mgf_pkg::ADDR_OV_SETUP: rdata_nxt = ov_setup_r;
         mgf_pkg::ADDR_OV_FLAGS: rdata_nxt = {5'h00, flags_r};
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Input synchronisers, three stages, change taken when 2 and 3 agree
   // Comparators first, then pins; order matches the decode wires above
   wire [NS-1:0] raw_in = {uio_in, cc_ov_cmp, bus_ov_cmp, dataline_ov_cmp};
   genvar g;
   generate
      for (g = 0; g < NS; g++) begin : g_sync
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               s1_r[g] <= 1'b0;
               s2_r[g] <= 1'b0;
               s3_r[g] <= 1'b0;
               stable_r[g] <= 1'b0;
            end else begin
               s1_r[g] <= raw_in[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               if (s2_r[g] == s3_r[g]) begin
                  stable_r[g] <= s3_r[g];
               end
            end
         end
      end
   endgenerate

   // Writable registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         adc_setup_r <= mgf_pkg::RST_ADC_SETUP;
         dir_r <= 3'h0;
         drive_r <= 3'h0;
         role_r <= 1'b0;
         ov_setup_r <= mgf_pkg::RST_ZERO;
      end else begin
         if (wr_adc) adc_setup_r <= reg_wdata;
         if (wr_dir) dir_r <= reg_wdata[2:0];
         if (wr_drive) drive_r <= reg_wdata[2:0];
         if (wr_role) role_r <= reg_wdata[mgf_pkg::ROLE_BIT];
         if (wr_ov) ov_setup_r <= reg_wdata;
      end
   end

   // Scan timer, debounce and results
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         scan_cnt_r <= 32'h0;
         adc_start <= 1'b0;
         rep_r <= 2'h0;
         bus_current_r <= 8'h00;
         therm_r <= 8'h00;
      end else begin
         scan_cnt_r <= (scan_hit || wr_adc) ? 32'h0 : scan_cnt_r + 32'h1;
         adc_start <= scan_hit || (adc_done && !latch_result);
         if (adc_done) begin
            rep_r <= latch_result ? 2'h0 : rep_r + 2'h1;
         end
         if (latch_result) begin
            bus_current_r <= adc_bus_current_code;
            therm_r <= adc_thermistor_code;
         end
      end
   end

   // Flags, pins and analog controls
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         flags_r <= 3'h0;
         reg_rdata <= 8'h00;
         uio_out <= 3'h0;
         uio_oe <= 3'h0;
         role_settled <= 1'b0;
         thermistor_bias_select <= 2'h0;
         dataline_overvolt_level <= 1'b0;
         dataline_overvolt_check <= 1'b0;
         bus_overvolt_check <= 1'b0;
         bus_overvolt_threshold <= 4'h0;
      end else begin
         flags_r <= flags_nxt;
         reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
         uio_out[1:0] <= drive_r[1:0];
         uio_oe[1:0] <= dir_r[1:0];
         uio_out[2] <= alarm_en ? alarm_level : drive_r[2];
         uio_oe[2] <= alarm_en | dir_r[2];
         role_settled <= role_r;
         thermistor_bias_select <= adc_setup_r[mgf_pkg::BIAS_LSB +: 2];
         dataline_overvolt_level <= ov_setup_r[mgf_pkg::DL_LEVEL_BIT];
         dataline_overvolt_check <= ov_setup_r[mgf_pkg::DL_CHECK_BIT];
         bus_overvolt_check <= ov_setup_r[mgf_pkg::BUS_CHECK_BIT];
         bus_overvolt_threshold <= ov_setup_r[mgf_pkg::BUS_THR_LSB +: 4];
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   AST_BIAS_FOLLOWS_WRITE: assert property (
      wr_adc |-> ##2 thermistor_bias_select == $past(reg_wdata[6:5], 2))
      else $error("bias select does not follow write");
   AST_RESULT_ONLY_ON_DONE: assert property (
      !$stable(bus_current_r) |-> $past(adc_done) && $past(rep_r) >= $past(deb_code))
      else $error("result changed outside final debounce sample");
   AST_START_IS_PULSE: assert property (
      adc_start && $past(scan_hit) |=> !adc_start || $past(adc_done))
      else $error("start pulse stretched");
   AST_BUS_CURRENT_LATCH: assert property (
      latch_result |=> bus_current_r == $past(adc_bus_current_code))
      else $error("bus current not captured");
   AST_THERM_LATCH: assert property (
      latch_result |=> therm_r == $past(adc_thermistor_code))
      else $error("thermistor code not captured");
   AST_DIR_TO_OE: assert property (
      wr_dir |-> ##2 uio_oe[0] == $past(reg_wdata[0], 2))
      else $error("pin 0 enable does not follow direction");
   AST_DRIVE_TO_PIN: assert property (
      wr_drive ##1 !wr_drive |=> uio_out[1] == $past(reg_wdata[1], 2))
      else $error("pin 1 level does not follow data");
   AST_ROLE: assert property (
      wr_role |-> ##2 role_settled == $past(reg_wdata[5], 2))
      else $error("role settled not applied");
   AST_ALARM_HIGH: assert property (
      alarm_en && (|flags_r) |=> uio_out[2] && uio_oe[2])
      else $error("alarm not driven");
   AST_BUS_GATED: assert property (
      $rose(flags_r[1]) |-> $past(ov_setup_r[4]))
      else $error("bus flag set while check disabled");
   AST_DL_GATED: assert property (
      $rose(flags_r[2]) |-> $past(ov_setup_r[5]))
      else $error("data-line flag set while check disabled");
   AST_CC_FLAG: assert property (
      cc_ov |=> flags_r[0])
      else $error("config channel flag missed");
   AST_PIN2_RELEASE: assert property (
      !alarm_en && !dir_r[2] |=> !uio_oe[2])
      else $error("pin 2 driven with alarm off and input");
   AST_RSVD_ZERO: assert property (
      reg_rd && reg_addr == mgf_pkg::ADDR_UIO_DIR |=> reg_rdata[7:3] == 5'h00)
      else $error("reserved bits read non-zero");
   AST_OE_PINS: assert property (
      wr_dir |-> ##2 uio_oe[1:0] == $past(reg_wdata[1:0], 2))
      else $error("pin enables do not follow direction");
   AST_DRIVE_PIN0: assert property (
      wr_drive |-> ##2 uio_out[0] == $past(reg_wdata[0], 2))
      else $error("pin 0 level does not follow data");
   AST_SAMPLED_READ: assert property (
      reg_rd && reg_addr == mgf_pkg::ADDR_UIO_SAMPLED |=>
         reg_rdata == {5'h00, $past(uio_sampled)})
      else $error("sampled pin levels not returned");

   // Scan timer and debounce round
   AST_SCAN_RESTART: assert property (
      scan_hit |=> adc_start && scan_cnt_r == 32'h0)
      else $error("scan timer did not restart with a start pulse");
   AST_SCAN_COUNT: assert property (
      !scan_hit && !wr_adc |=> scan_cnt_r == $past(scan_cnt_r) + 32'h1)
      else $error("scan timer skipped a cycle");
   AST_DEB_REPEAT: assert property (
      adc_done && !latch_result |=> adc_start)
      else $error("debounce repetition not started");
   AST_DEB_FINAL: assert property (
      latch_result && !scan_hit |=> !adc_start)
      else $error("extra start after final debounce sample");
   AST_REP_CLEAR: assert property (
      latch_result |=> rep_r == 2'h0)
      else $error("repetition count not cleared after result");

   // Overvoltage controls follow the setup register two edges after a write
   AST_DL_LEVEL: assert property (
      wr_ov |-> ##2 dataline_overvolt_level == $past(reg_wdata[mgf_pkg::DL_LEVEL_BIT], 2))
      else $error("data-line level select not applied");
   AST_DL_CHECK_OUT: assert property (
      wr_ov |-> ##2 dataline_overvolt_check == $past(reg_wdata[mgf_pkg::DL_CHECK_BIT], 2))
      else $error("data-line check enable not applied");
   AST_BUS_CHECK_OUT: assert property (
      wr_ov |-> ##2 bus_overvolt_check == $past(reg_wdata[mgf_pkg::BUS_CHECK_BIT], 2))
      else $error("bus check enable not applied");
   AST_THR_FOLLOWS: assert property (
      wr_ov |-> ##2 bus_overvolt_threshold == $past(reg_wdata[3:0], 2))
      else $error("bus threshold select not applied");
   AST_ALARM_OFF: assert property (
      !alarm_en |=> uio_out[2] == $past(drive_r[2]))
      else $error("alarm driven while disabled");

   // Flag reads: data is the pre-clear value, and a quiet comparator clears
   AST_FLAG_READ: assert property (
      rd_flags |=> reg_rdata == {5'h00, $past(flags_r)})
      else $error("flag read data wrong");
   AST_FLAG_CLEAR: assert property (
      rd_flags && !bus_ov |=> !flags_r[mgf_pkg::FLAG_BUS])
      else $error("bus flag not cleared by read");
endmodule : mgf_regs

// File: verification/mgf_host_model.sv
// Host model: the port manager doing single byte writes and reads.
// Assumes one-cycle strobes and read data valid one cycle after the strobe.
`timescale 1ns/100ps
module mgf_host_model (
   input wire logic clock, // System clock
   input wire logic [7:0] reg_rdata, // Read data
   output logic [7:0] reg_addr, // Register offset
   output logic [7:0] reg_wdata, // Write data
   output logic reg_wr, // Write strobe
   output logic reg_rd // Read strobe
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Callers order writes so direction precedes data
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clock);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clock);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
endmodule : mgf_host_model

// File: verification/test_monitor_gpio_fault_regs.sv
// Testbench for the monitor, user I/O and fault register bank.
// Assumes the host model on the register port and a short millisecond count.
`timescale 1ns/100ps
module test_monitor_gpio_fault_regs;
   localparam int MS = 4;
   logic clock, nrst, adc_start, role_settled, reg_wr, reg_rd;
   logic adc_done = 1'b0;
   logic dl_level, dl_check, bus_check;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
   logic [7:0] cur_code = 8'h00, th_code = 8'h00;
   logic [1:0] bias;
   logic [3:0] bus_thr;
   logic [2:0] uio_in, uio_out, uio_oe, cmp;
   logic [31:0] seed = 32'hcab017a3;
   logic [7:0] addrs [10] = '{8'hc3, 8'hc4, 8'hc0, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc5};
   int img [int];
   int dly = 0;
   int error_cnt = 0;
   int samples_checked = 0;
   mgf_host_model host_u (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
   mgf_regs #(.MS_CYCLES(MS)) dut_u (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .adc_start(adc_start), .adc_done(adc_done), .adc_bus_current_code(cur_code),
      .adc_thermistor_code(th_code), .thermistor_bias_select(bias), .uio_in(uio_in),
      .uio_out(uio_out), .uio_oe(uio_oe), .role_settled(role_settled),
      .dataline_ov_cmp(cmp[2]), .bus_ov_cmp(cmp[1]), .cc_ov_cmp(cmp[0]),
      .dataline_overvolt_level(dl_level), .dataline_overvolt_check(dl_check),
      .bus_overvolt_check(bus_check), .bus_overvolt_threshold(bus_thr));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic int mask(input int a);
      case (a)
         8'hc0, 8'hcc: return 8'hff;
         8'hc8, 8'hc9: return 8'h07;
         8'hcb: return 8'h20;
         default: return 0;
      endcase
   endfunction : mask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host_u.rd(a, rd_v);
      chk(16'(rd_v), 16'(e));
   endtask : rchk
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic to_start(output int n);
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (adc_start !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         error_cnt++;
         $display("unexpected at %0t: no conversion start", $time);
         wrap_up();
      end
   endtask : to_start
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Converter: answers each start three edges later with fresh codes
   always @(posedge clock) begin
      #1;
      if (dly == 1) begin
         cur_code = cur_code + 8'h5d;
         th_code = cur_code ^ 8'ha6;
         img['hc3] = cur_code;
         img['hc4] = th_code;
      end
      adc_done = (dly == 1);
      if (adc_start === 1'b1)
         dly = 3;
      else if (dly > 0)
         dly--;
   end
   initial begin
      int n;
      logic [7:0] v, ov, dir, drv;
      logic [2:0] f;
      nrst = 1'b0;
      uio_in = 3'h0;
      cmp = 3'h0;
      for (int a = 'hc0; a <= 'hcd; a++)
         img[a] = 0;
      img['hc0] = 8'h81;
      repeat (6) @(posedge clock);
      #1;
      nrst = 1'b1;
      chk(16'(uio_oe), 16'h0000);
      foreach (addrs[k])
         rchk(addrs[k], 8'(img[addrs[k]]));
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         uio_in = seed[2:0];
         img['hca] = uio_in;
         foreach (addrs[k]) begin
            seed = lfsr(seed);
            v = seed[7:0];
            host_u.wr(addrs[k], v);
            if (mask(addrs[k]) != 0)
               img[addrs[k]] = v & mask(addrs[k]);
         end
         for (int k = 2; k < 10; k++)
            rchk(addrs[k], 8'(img[addrs[k]]));
         v = 8'(img['hc0]);
         ov = 8'(img['hcc]);
         dir = 8'(img['hc8]);
         drv = 8'(img['hc9]);
         chk(16'(bias), 16'(v[6:5]));
         chk(16'(role_settled), 16'(img['hcb] >> 5));
         chk(16'({dl_level, dl_check, bus_check, bus_thr}), 16'(ov[6:0]));
         chk(16'(uio_oe), 16'({dir[2] | ov[7], dir[1:0]}));
         chk(16'(uio_out & uio_oe), 16'({~ov[7] & dir[2] & drv[2], dir[1:0] & drv[1:0]}));
      end
      for (int i = 0; i < 6; i++) begin
         ov = (i < 3) ? 8'hf0 : 8'h40;
         host_u.wr(8'hcc, ov);
         cmp = 3'h1 << (i % 3);
         f = cmp & {ov[5], ov[4], 1'b1};
         repeat (8) @(posedge clock);
         #1;
         cmp = 3'h0;
         repeat (6) @(posedge clock);
         #1;
         chk(16'(uio_oe[2]), 16'(ov[7] | dir[2]));
         chk(16'(uio_out[2] & uio_oe[2]), 16'(ov[7] ? |f : dir[2] & drv[2]));
         rchk(8'hcd, 8'(f));
         rchk(8'hcd, 8'h00);
      end
      for (int c = 0; c < 8; c++) begin
         host_u.wr(8'hc0, 8'(c));
         to_start(n);
         to_start(n);
         chk(16'(n), 16'(MS << ((c > 5 ? 5 : c) + 2)));
      end
      for (int d = 0; d < 4; d++) begin
         host_u.wr(8'hc0, 8'(8'h02 | (d << 3)));
         to_start(n);
         n = 0;
         repeat (40) begin
            @(posedge clock);
            #1;
            n += int'(adc_start === 1'b1);
         end
         chk(16'(n), 16'(d));
         rchk(8'hc3, 8'(img['hc3]));
         rchk(8'hc4, 8'(img['hc4]));
      end
      wrap_up();
   end
endmodule : test_monitor_gpio_fault_regs
